// File: rtl/pic_pkg.sv
package pic_pkg;
  localparam int unsigned NUM_LEVELS = 8;
  localparam int unsigned NUM_STROBES = 3;
  localparam int unsigned STB_RD = 0;
  localparam int unsigned STB_WR = 1;
  localparam int unsigned STB_ACK = 2;

  // Reset and init defaults
  localparam logic [2:0] BOTTOM_RESET = 3'h7;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] ACK_CNT_RESET = 2'h0;

  // Init word one fields
  localparam int unsigned W1_MARK_BIT = 4;
  localparam int unsigned W1_LEVEL_SENSE_BIT = 3;
  localparam int unsigned W1_SPACING4_BIT = 2;
  localparam int unsigned W1_SINGLE_BIT = 1;
  localparam int unsigned W1_NEED_W4_BIT = 0;
  localparam logic [2:0] W1_SPACING8_KEEP = 3'h6;

  // Init word four fields
  localparam int unsigned W4_NESTED_BIT = 4;
  localparam int unsigned W4_BUFFERED_BIT = 3;
  localparam int unsigned W4_MASTER_BIT = 2;
  localparam int unsigned W4_AUTO_BIT = 1;
  localparam int unsigned W4_TWO_PULSE_BIT = 0;

  // Op word three fields
  localparam int unsigned OP3_MARK_BIT = 3;
  localparam int unsigned OP3_SMM_EN_BIT = 6;
  localparam int unsigned OP3_SMM_BIT = 5;
  localparam int unsigned OP3_POLL_BIT = 2;
  localparam int unsigned OP3_READ_EN_BIT = 1;
  localparam int unsigned OP3_READ_PICK_BIT = 0;

  // Op word two commands on D7..D5
  localparam logic [2:0] OP2_NONSPEC = 3'h1;
  localparam logic [2:0] OP2_SPEC = 3'h3;
  localparam logic [2:0] OP2_ROT_NONSPEC = 3'h5;
  localparam logic [2:0] OP2_ROT_SPEC = 3'h7;
  localparam logic [2:0] OP2_SET_ROT = 3'h4;
  localparam logic [2:0] OP2_CLR_ROT = 3'h0;
  localparam logic [2:0] OP2_SET_BOTTOM = 3'h6;

  // Acknowledge sequence
  localparam logic [7:0] CALL_OPCODE = 8'hcd;
  localparam logic [1:0] LAST_PULSE_TWO = 2'h1;
  localparam logic [1:0] LAST_PULSE_THREE = 2'h2;

  typedef enum logic [1:0] {
    PIC_READY = 2'b00,
    PIC_WAIT_W2 = 2'b01,
    PIC_WAIT_W3 = 2'b10,
    PIC_WAIT_W4 = 2'b11
  } pic_init_e;
endpackage : pic_pkg

// File: rtl/pic_strobe_if.sv
`timescale 1ns/100ps
interface pic_strobe_if;
  logic [2:0] low;
  logic [2:0] fall;
  logic [2:0] rise;
  modport src (output low, output fall, output rise);
  modport snk (input low, input fall, input rise);
endinterface : pic_strobe_if

// File: rtl/pic_strobe.sv
`timescale 1ns/100ps
module pic_strobe (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic [2:0] strobe_n_in,
  pic_strobe_if.src stb
);
  logic [2:0] prev_n_r;
  logic [2:0] prev_n_nxt;

  always_comb
  begin
    prev_n_nxt = strobe_n_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      prev_n_r <= 3'h7;
    else if (clk_en_in)
      prev_n_r <= prev_n_nxt;
  end

  genvar g;
  generate
    for (g = 0; g < pic_pkg::NUM_STROBES; g++)
    begin : g_stb
      assign stb.low[g] = ~strobe_n_in[g];
      assign stb.fall[g] = prev_n_r[g] & ~strobe_n_in[g] & clk_en_in;
      assign stb.rise[g] = ~prev_n_r[g] & strobe_n_in[g] & clk_en_in;
    end
  endgenerate
endmodule : pic_strobe

// File: rtl/pic_resolve.sv
`timescale 1ns/100ps
module pic_resolve (
  input wire logic [7:0] vec_in,
  input wire logic [2:0] bottom_in,
  output logic found_out,
  output logic [2:0] level_out,
  output logic [2:0] rank_out
);
  // Rank 0 is the level just above the bottom one, wrapping
  always_comb
  begin
    logic [2:0] lvl;
    lvl = 3'h0;
    found_out = 1'b0;
    level_out = 3'h0;
    rank_out = 3'h7;
    for (int k = pic_pkg::NUM_LEVELS - 1; k >= 0; k--)
    begin
      lvl = bottom_in + 3'(k + 1); // R4
      if (vec_in[lvl])
      begin
        found_out = 1'b1;
        level_out = lvl;
        rank_out = 3'(k);
      end
    end
  end
endmodule : pic_resolve

// File: rtl/pic_core.sv
`timescale 1ns/100ps
// What this block does
// R1: Auto rotation gives the serviced level lowest priority, so waits are bounded.
// R2: Op word two with rotate and end set, untargeted, ends service and rotates.
// R3: Rotate without end sets the rotate flag for auto mode; all-zero clears it.
// R4: Software rotation makes the level above the programmed bottom highest, wrapping.
// R5: Rotate plus targeted bit sets bottom from low three bits, alone or with end.
// R6: Level-sense select makes a high input a request, no edge needed.
// R7: Level-sensed sources must drop their request before end-of-service.
// R8: Status read enabled with pick zero returns pending requests on port zero.
// R9: Status read enabled with pick one returns in-service bits on port zero.
// R10: Status selection is kept until changed, defaults to pending after init.
// R11: Reads on port one always return the mask bits.
// R12: Poll with read enable makes the next read return poll information.
// R13: Acknowledge clears the highest-priority unmasked pending request; masked requests stay pending.
// R14: In-service bits track serviced levels and change on end-of-service.
// R15: Init word one decodes sensing, spacing, single mode, word four, vector bits.
// R16: Init word two on port one supplies the upper vector byte.
// R17: Init word three is taken as cascade map or slave identifier.
// R18: Init word four selects host type, auto end, buffered mode, master or slave.
// R19: Init word four bit four adds special fully nested operation.
// R20: Port one writes after init load the mask bits; reads return them.
// R21: Op word two D7 to D5 decode into the seven end and rotate commands.
// R22: Op word three sets special masking, poll, and status read selection.
// R23: Auto end does an untargeted end at the last acknowledge pulse's trailing edge.
// R24: Untargeted end clears the highest-priority in-service bit.
module pic_core (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic inta_n_in,
  input wire logic port_select_bit_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  input wire logic [7:0] request_inputs_in,
  output logic int_out,
  output logic buf_en_n_out
);
  pic_strobe_if stb ();

  pic_strobe u_strobe (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .strobe_n_in({inta_n_in, wr_n_in, rd_n_in}),
    .stb(stb.src)
  );

  pic_pkg::pic_init_e state_r, state_nxt;
  logic [7:0] mask_bits_r, mask_bits_nxt;
  logic [7:0] pending_request_bits_r, pending_request_bits_nxt;
  logic [7:0] in_service_bits_r, in_service_bits_nxt;
  logic [7:0] req_prev_r, req_prev_nxt;
  logic [7:0] vec_hi_r, vec_hi_nxt;
  logic [7:0] cascade_map_fields_r, cascade_map_fields_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic [2:0] vec_lo_r, vec_lo_nxt;
  logic [2:0] bottom_r, bottom_nxt;
  logic [2:0] ack_level_r, ack_level_nxt;
  logic [1:0] ack_cnt_r, ack_cnt_nxt;
  logic level_sense_select_r, level_sense_select_nxt;
  logic spacing4_r, spacing4_nxt;
  logic single_r, single_nxt;
  logic need_w4_r, need_w4_nxt;
  logic two_pulse_r, two_pulse_nxt;
  logic auto_service_done_r, auto_service_done_nxt;
  logic buffered_r, buffered_nxt;
  logic master_r, master_nxt;
  logic nested_r, nested_nxt;
  logic rotate_flag_r, rotate_flag_nxt;
  logic special_mask_r, special_mask_nxt;
  logic status_read_pick_r, status_read_pick_nxt;
  logic poll_r, poll_nxt;
  logic rd_act_r, rd_act_nxt;
  logic ack_drive_r, ack_drive_nxt;
  logic int_r, int_nxt;

  logic [7:0] irr_hold;
  logic [7:0] req_vec;
  logic [7:0] isr_eff;
  logic req_found, is_found;
  logic [2:0] req_level, is_level, req_rank, is_rank;
  logic [1:0] last_pulse;
  logic blocked;

  genvar g;
  generate
    for (g = 0; g < pic_pkg::NUM_LEVELS; g++)
    begin : g_req
      // Edge mode keeps the latch only while the input stays high
      assign irr_hold[g] = request_inputs_in[g]
        & (level_sense_select_r | pending_request_bits_r[g] | ~req_prev_r[g]); // R6
    end
  endgenerate

  assign req_vec = pending_request_bits_r & ~mask_bits_r;
  // Masked levels stop inhibiting in special mask mode
  assign isr_eff = in_service_bits_r & ~(special_mask_r ? mask_bits_r : 8'h00);

  pic_resolve u_req (
    .vec_in(req_vec),
    .bottom_in(bottom_r),
    .found_out(req_found),
    .level_out(req_level),
    .rank_out(req_rank)
  );

  pic_resolve u_isr (
    .vec_in(isr_eff),
    .bottom_in(bottom_r),
    .found_out(is_found),
    .level_out(is_level),
    .rank_out(is_rank)
  );

  assign last_pulse = two_pulse_r ? pic_pkg::LAST_PULSE_TWO : pic_pkg::LAST_PULSE_THREE;
  // Same level in service blocks, except in special fully nested mode
  assign blocked = is_found & ((req_rank > is_rank) | ((req_rank == is_rank) & ~nested_r)); // R19

  always_comb
  begin
    state_nxt = state_r;
    mask_bits_nxt = mask_bits_r;
    pending_request_bits_nxt = irr_hold;
    in_service_bits_nxt = in_service_bits_r;
    req_prev_nxt = request_inputs_in;
    vec_hi_nxt = vec_hi_r;
    cascade_map_fields_nxt = cascade_map_fields_r;
    dout_nxt = dout_r;
    vec_lo_nxt = vec_lo_r;
    bottom_nxt = bottom_r;
    ack_level_nxt = ack_level_r;
    ack_cnt_nxt = ack_cnt_r;
    level_sense_select_nxt = level_sense_select_r;
    spacing4_nxt = spacing4_r;
    single_nxt = single_r;
    need_w4_nxt = need_w4_r;
    two_pulse_nxt = two_pulse_r;
    auto_service_done_nxt = auto_service_done_r;
    buffered_nxt = buffered_r;
    master_nxt = master_r;
    nested_nxt = nested_r;
    rotate_flag_nxt = rotate_flag_r;
    special_mask_nxt = special_mask_r;
    status_read_pick_nxt = status_read_pick_r;
    poll_nxt = poll_r;
    rd_act_nxt = rd_act_r;
    ack_drive_nxt = ack_drive_r;
    int_nxt = req_found & ~blocked;

    // Register writes, taken at the leading edge of a selected write
    if (stb.fall[pic_pkg::STB_WR] && !cs_n_in)
    begin
      if (!port_select_bit_in && data_in[pic_pkg::W1_MARK_BIT])
      begin
        level_sense_select_nxt = data_in[pic_pkg::W1_LEVEL_SENSE_BIT]; // R15
        spacing4_nxt = data_in[pic_pkg::W1_SPACING4_BIT]; // R15
        single_nxt = data_in[pic_pkg::W1_SINGLE_BIT]; // R15
        need_w4_nxt = data_in[pic_pkg::W1_NEED_W4_BIT]; // R15
        vec_lo_nxt = data_in[7:5] & (data_in[pic_pkg::W1_SPACING4_BIT] ? 3'h7 : pic_pkg::W1_SPACING8_KEEP); // R15
        mask_bits_nxt = pic_pkg::BYTE_RESET;
        in_service_bits_nxt = pic_pkg::BYTE_RESET;
        pending_request_bits_nxt = pic_pkg::BYTE_RESET;
        bottom_nxt = pic_pkg::BOTTOM_RESET;
        two_pulse_nxt = 1'b0;
        auto_service_done_nxt = 1'b0;
        buffered_nxt = 1'b0;
        master_nxt = 1'b0;
        nested_nxt = 1'b0;
        rotate_flag_nxt = 1'b0;
        special_mask_nxt = 1'b0;
        status_read_pick_nxt = 1'b0; // R10
        poll_nxt = 1'b0;
        ack_cnt_nxt = pic_pkg::ACK_CNT_RESET;
        state_nxt = pic_pkg::PIC_WAIT_W2;
      end
      else
      begin
        case (state_r)
          pic_pkg::PIC_WAIT_W2:
          begin
            if (port_select_bit_in)
            begin
              vec_hi_nxt = data_in; // R16
              if (!single_r)
                state_nxt = pic_pkg::PIC_WAIT_W3;
              else if (need_w4_r)
                state_nxt = pic_pkg::PIC_WAIT_W4;
              else
                state_nxt = pic_pkg::PIC_READY;
            end
          end
          pic_pkg::PIC_WAIT_W3:
          begin
            if (port_select_bit_in)
            begin
              cascade_map_fields_nxt = data_in; // R17
              state_nxt = need_w4_r ? pic_pkg::PIC_WAIT_W4 : pic_pkg::PIC_READY;
            end
          end
          pic_pkg::PIC_WAIT_W4:
          begin
            if (port_select_bit_in)
            begin
              two_pulse_nxt = data_in[pic_pkg::W4_TWO_PULSE_BIT]; // R18
              auto_service_done_nxt = data_in[pic_pkg::W4_AUTO_BIT]; // R18
              buffered_nxt = data_in[pic_pkg::W4_BUFFERED_BIT]; // R18
              master_nxt = data_in[pic_pkg::W4_BUFFERED_BIT] & data_in[pic_pkg::W4_MASTER_BIT]; // R18
              nested_nxt = data_in[pic_pkg::W4_NESTED_BIT]; // R19
              state_nxt = pic_pkg::PIC_READY;
            end
          end
          pic_pkg::PIC_READY:
          begin
            if (port_select_bit_in)
              mask_bits_nxt = data_in; // R20
            else if (data_in[pic_pkg::OP3_MARK_BIT])
            begin
              if (data_in[pic_pkg::OP3_SMM_EN_BIT])
                special_mask_nxt = data_in[pic_pkg::OP3_SMM_BIT]; // R22
              if (data_in[pic_pkg::OP3_READ_EN_BIT])
                status_read_pick_nxt = data_in[pic_pkg::OP3_READ_PICK_BIT]; // R8 R9 R10 R22
              poll_nxt = data_in[pic_pkg::OP3_POLL_BIT]; // R12 R22
            end
            else
            begin
              case (data_in[7:5]) // R21
                pic_pkg::OP2_NONSPEC:
                begin
                  if (is_found)
                    in_service_bits_nxt[is_level] = 1'b0; // R24 R14
                end
                pic_pkg::OP2_SPEC:
                  in_service_bits_nxt[data_in[2:0]] = 1'b0; // R14
                pic_pkg::OP2_ROT_NONSPEC:
                begin
                  if (is_found)
                  begin
                    in_service_bits_nxt[is_level] = 1'b0; // R2 R24
                    bottom_nxt = is_level; // R1 R2
                  end
                end
                pic_pkg::OP2_ROT_SPEC:
                begin
                  in_service_bits_nxt[data_in[2:0]] = 1'b0; // R5
                  bottom_nxt = data_in[2:0]; // R5
                end
                pic_pkg::OP2_SET_BOTTOM:
                  bottom_nxt = data_in[2:0]; // R4 R5
                pic_pkg::OP2_SET_ROT:
                  rotate_flag_nxt = 1'b1; // R3
                pic_pkg::OP2_CLR_ROT:
                  rotate_flag_nxt = 1'b0; // R3
                default:
                  rotate_flag_nxt = rotate_flag_r;
              endcase
            end
          end
          default:
            state_nxt = pic_pkg::PIC_READY;
        endcase
      end
    end

    // Status reads; the port select is sampled at the leading edge
    if (stb.fall[pic_pkg::STB_RD] && !cs_n_in)
    begin
      rd_act_nxt = 1'b1;
      if (port_select_bit_in)
        dout_nxt = mask_bits_r; // R11 R20
      else if (poll_r)
      begin
        // A poll read acts as an acknowledge
        dout_nxt = {req_found, 4'h0, req_level}; // R12
        if (req_found)
        begin
          in_service_bits_nxt[req_level] = 1'b1;
          pending_request_bits_nxt[req_level] = 1'b0; // R13
        end
        poll_nxt = 1'b0;
      end
      else
        dout_nxt = status_read_pick_r ? in_service_bits_r : pending_request_bits_r; // R8 R9
    end
    if (stb.rise[pic_pkg::STB_RD])
      rd_act_nxt = 1'b0;

    // Acknowledge pulses
    if (stb.fall[pic_pkg::STB_ACK])
    begin
      ack_drive_nxt = !(two_pulse_r && ack_cnt_r == 2'h0);
      if (ack_cnt_r == 2'h0)
      begin
        // No request left: answer with level 7, no service bit
        ack_level_nxt = req_found ? req_level : 3'h7;
        if (req_found)
        begin
          in_service_bits_nxt[req_level] = 1'b1; // R14
          pending_request_bits_nxt[req_level] = 1'b0; // R13
        end
        dout_nxt = pic_pkg::CALL_OPCODE;
      end
      else if (two_pulse_r)
        dout_nxt = {vec_hi_r[7:3], ack_level_r};
      else if (ack_cnt_r == 2'h1)
        dout_nxt = spacing4_r ? {vec_lo_r, ack_level_r, 2'h0} : {vec_lo_r[2:1], ack_level_r, 3'h0};
      else
        dout_nxt = vec_hi_r;
    end
    if (stb.rise[pic_pkg::STB_ACK])
    begin
      ack_drive_nxt = 1'b0;
      if (ack_cnt_r >= last_pulse)
      begin
        ack_cnt_nxt = pic_pkg::ACK_CNT_RESET;
        if (auto_service_done_r && is_found)
        begin
          in_service_bits_nxt[is_level] = 1'b0; // R23 R24
          if (rotate_flag_r)
            bottom_nxt = is_level; // R1 R3
        end
      end
      else
        ack_cnt_nxt = ack_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= pic_pkg::PIC_READY;
      mask_bits_r <= pic_pkg::BYTE_RESET;
      pending_request_bits_r <= pic_pkg::BYTE_RESET;
      in_service_bits_r <= pic_pkg::BYTE_RESET;
      req_prev_r <= pic_pkg::BYTE_RESET;
      vec_hi_r <= pic_pkg::BYTE_RESET;
      cascade_map_fields_r <= pic_pkg::BYTE_RESET;
      dout_r <= pic_pkg::BYTE_RESET;
      vec_lo_r <= 3'h0;
      bottom_r <= pic_pkg::BOTTOM_RESET;
      ack_level_r <= 3'h0;
      ack_cnt_r <= pic_pkg::ACK_CNT_RESET;
      level_sense_select_r <= 1'b0;
      spacing4_r <= 1'b0;
      single_r <= 1'b0;
      need_w4_r <= 1'b0;
      two_pulse_r <= 1'b0;
      auto_service_done_r <= 1'b0;
      buffered_r <= 1'b0;
      master_r <= 1'b0;
      nested_r <= 1'b0;
      rotate_flag_r <= 1'b0;
      special_mask_r <= 1'b0;
      status_read_pick_r <= 1'b0;
      poll_r <= 1'b0;
      rd_act_r <= 1'b0;
      ack_drive_r <= 1'b0;
      int_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_r <= state_nxt;
      mask_bits_r <= mask_bits_nxt;
      pending_request_bits_r <= pending_request_bits_nxt;
      in_service_bits_r <= in_service_bits_nxt;
      req_prev_r <= req_prev_nxt;
      vec_hi_r <= vec_hi_nxt;
      cascade_map_fields_r <= cascade_map_fields_nxt;
      dout_r <= dout_nxt;
      vec_lo_r <= vec_lo_nxt;
      bottom_r <= bottom_nxt;
      ack_level_r <= ack_level_nxt;
      ack_cnt_r <= ack_cnt_nxt;
      level_sense_select_r <= level_sense_select_nxt;
      spacing4_r <= spacing4_nxt;
      single_r <= single_nxt;
      need_w4_r <= need_w4_nxt;
      two_pulse_r <= two_pulse_nxt;
      auto_service_done_r <= auto_service_done_nxt;
      buffered_r <= buffered_nxt;
      master_r <= master_nxt;
      nested_r <= nested_nxt;
      rotate_flag_r <= rotate_flag_nxt;
      special_mask_r <= special_mask_nxt;
      status_read_pick_r <= status_read_pick_nxt;
      poll_r <= poll_nxt;
      rd_act_r <= rd_act_nxt;
      ack_drive_r <= ack_drive_nxt;
      int_r <= int_nxt;
    end
  end

  assign data_out = dout_r;
  assign data_oe_out = rd_act_r | ack_drive_r;
  assign int_out = int_r;
  // Transceiver enable only in buffered mode
  assign buf_en_n_out = ~(buffered_r & (rd_act_r | ack_drive_r)); // R18
endmodule : pic_core

// File: sim/pic_core_properties.sv
`timescale 1ns/100ps
module pic_core_properties (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic inta_n_in,
  input wire logic port_select_bit_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_out,
  input wire logic [7:0] request_inputs_in,
  input wire logic int_out,
  input wire logic buf_en_n_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_rst; disable iff (1'h0) !rst_n_in |=> !data_oe_out && !int_out && buf_en_n_out; endproperty
  a_rst: assert property (p_rst) else $error("outputs not quiet in reset");
  property p_rd; clk_en_in && !cs_n_in && $fell(rd_n_in) |=> data_oe_out; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_drop; rd_n_in && inta_n_in |=> !data_oe_out; endproperty
  a_drop: assert property (p_drop) else $error("bus driven after strobe");
  property p_buf; !data_oe_out |-> buf_en_n_out; endproperty
  a_buf: assert property (p_buf) else $error("transceiver enabled while idle");
  property p_cause; data_oe_out |-> !$past(rd_n_in) || !$past(inta_n_in); endproperty
  a_cause: assert property (p_cause) else $error("bus driven without strobe");
  property p_stable; data_oe_out && $past(data_oe_out) |-> $stable(data_out); endproperty
  a_stable: assert property (p_stable) else $error("read data moved");
  property p_idle; request_inputs_in == 8'h00 [*3] |=> !int_out; endproperty
  a_idle: assert property (p_idle) else $error("interrupt with no request");
  property p_rose; $rose(int_out) |-> ($past(request_inputs_in) | $past(request_inputs_in, 2)) != 8'h00; endproperty
  a_rose: assert property (p_rose) else $error("interrupt rose without request");
endmodule : pic_core_properties

bind pic_core pic_core_properties chk_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
  .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .inta_n_in(inta_n_in),
  .port_select_bit_in(port_select_bit_in), .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
  .request_inputs_in(request_inputs_in), .int_out(int_out), .buf_en_n_out(buf_en_n_out));

// File: sim/pic_host_model.sv
`timescale 1ns/100ps
module pic_host_model (
  input wire logic mclk_in,
  input wire logic [7:0] data_in,
  input wire logic data_oe_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic inta_n_out,
  output logic port_select_bit_out,
  output logic [7:0] data_out
);
  initial
  begin
    cs_n_out = 1'h1;
    rd_n_out = 1'h1;
    wr_n_out = 1'h1;
    inta_n_out = 1'h1;
    port_select_bit_out = 1'h0;
    data_out = 8'h00;
  end
  // Released bus shows inverted data, never the last value
  task automatic wr(input logic a, input logic [7:0] d);
    @(negedge mclk_in);
    cs_n_out = 1'h0;
    port_select_bit_out = a;
    data_out = d;
    wr_n_out = 1'h0;
    @(negedge mclk_in);
    wr_n_out = 1'h1;
    cs_n_out = 1'h1;
    data_out = ~d;
  endtask : wr
  // Read or acknowledge pulse; returns enable and data
  task automatic xfer(input logic ack, input logic a, output logic [8:0] v);
    @(negedge mclk_in);
    port_select_bit_out = a;
    cs_n_out = ack;
    if (ack)
      inta_n_out = 1'h0;
    else
      rd_n_out = 1'h0;
    repeat (2) @(negedge mclk_in);
    v = {data_oe_in, data_in};
    rd_n_out = 1'h1;
    inta_n_out = 1'h1;
    cs_n_out = 1'h1;
    @(negedge mclk_in);
  endtask : xfer
endmodule : pic_host_model

// File: sim/pic_core_tb_top.sv
`timescale 1ns/100ps
module pic_core_tb_top;
  logic mclk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic cs_n, rd_n, wr_n, inta_n, psel, oe, irq, ben_n;
  logic [7:0] din, dout, req, vec, p;
  logic [8:0] v;
  int n_errors = 0;
  int cmp_count = 0;
  logic ben_seen = 1'h1;

  initial forever #5 mclk_in = ~mclk_in;

  // Transceiver enable as seen while the bus is driven
  always @(negedge mclk_in)
    if (oe)
      ben_seen <= ben_n;

  pic_host_model host_u (.mclk_in(mclk_in), .data_in(dout), .data_oe_in(oe), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .inta_n_out(inta_n), .port_select_bit_out(psel), .data_out(din));

  pic_core dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .clk_en_in(1'h1), .cs_n_in(cs_n),
    .rd_n_in(rd_n), .wr_n_in(wr_n), .inta_n_in(inta_n), .port_select_bit_in(psel), .data_in(din),
    .data_out(dout), .data_oe_out(oe), .request_inputs_in(req), .int_out(irq), .buf_en_n_out(ben_n));

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic rdc(input logic a, input logic [7:0] exp, input string what);
    host_u.xfer(1'h0, a, v);
    check(what, v, {1'h1, exp});
  endtask : rdc

  task automatic pollc(input logic [7:0] exp);
    host_u.wr(1'h0, 8'h0c);
    rdc(1'h0, exp, "poll");
  endtask : pollc

  // Low cycle first so edge sensing sees a fresh rise
  task automatic setreq(input logic [7:0] x);
    @(negedge mclk_in);
    req = 8'h00;
    @(negedge mclk_in);
    req = x;
    @(negedge mclk_in);
  endtask : setreq

  // Level above the bottom wins, wrapping
  function automatic logic [7:0] poll_exp(input logic [7:0] r, input logic [2:0] b);
    logic [2:0] l;
    for (int i = 1; i <= 8; i++)
    begin
      l = b + 3'(i);
      if (r[l])
        return {5'h10, l};
    end
    return 8'h00;
  endfunction : poll_exp

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'h54f1ccc9));
    req = 8'h00;
    repeat (16) @(negedge mclk_in);
    rst_n_in = 1'h1;
    repeat (2) @(negedge mclk_in);
    host_u.wr(1'h0, 8'hb7);
    host_u.wr(1'h1, 8'h40);
    host_u.wr(1'h1, 8'h00);
    rdc(1'h1, 8'h00, "mask_init");
    check("ben_unbuf", {8'h00, ben_seen}, 9'h001);
    rdc(1'h0, 8'h00, "pend_init");
    vec = 8'($urandom);
    host_u.wr(1'h1, vec);
    rdc(1'h1, vec, "mask");
    host_u.wr(1'h1, 8'h00);
    setreq(8'h24);
    rdc(1'h0, 8'h24, "pend");
    host_u.xfer(1'h1, 1'h0, v);
    check("ack1", v, 9'h1cd);
    host_u.xfer(1'h1, 1'h0, v);
    check("ack2", v, 9'h1a8);
    host_u.xfer(1'h1, 1'h0, v);
    check("ack3", v, 9'h140);
    host_u.wr(1'h0, 8'h0b);
    rdc(1'h0, 8'h04, "isr");
    rdc(1'h0, 8'h04, "isr_kept");
    check("int_blocked", {8'h00, irq}, 9'h000);
    host_u.wr(1'h1, 8'h04);
    host_u.wr(1'h0, 8'h68);
    @(negedge mclk_in);
    check("int_smm", {8'h00, irq}, 9'h001);
    host_u.wr(1'h0, 8'h48);
    host_u.wr(1'h1, 8'h00);
    host_u.wr(1'h0, 8'h0a);
    rdc(1'h0, 8'h20, "pend_ack");
    host_u.wr(1'h0, 8'h20);
    host_u.wr(1'h0, 8'h0b);
    rdc(1'h0, 8'h00, "isr_eoi");
    check("int_after_eoi", {8'h00, irq}, 9'h001);
    $display("test init_ack done");
    for (int i = 0; i < 8; i++)
    begin
      vec = 8'($urandom) | 8'h01;
      host_u.wr(1'h0, {5'h18, 3'(i)});
      setreq(vec);
      p = poll_exp(vec, 3'(i));
      pollc(p);
      host_u.wr(1'h0, {5'h0c, p[2:0]});
    end
    $display("test bottom done");
    host_u.wr(1'h0, 8'hc7);
    setreq(8'h10);
    pollc(8'h84);
    host_u.wr(1'h0, 8'ha0);
    setreq(8'h28);
    pollc(8'h85);
    host_u.wr(1'h0, 8'he5);
    setreq(8'h21);
    pollc(8'h80);
    host_u.wr(1'h0, 8'h60);
    $display("test rotate done");
    host_u.wr(1'h0, 8'hb9);
    host_u.wr(1'h1, 8'h48);
    host_u.wr(1'h1, 8'h5a);
    host_u.wr(1'h1, 8'h1b);
    rdc(1'h1, 8'h00, "mask_after_w3");
    rdc(1'h0, 8'h21, "pend_level");
    host_u.wr(1'h0, 8'hc7);
    setreq(8'h08);
    host_u.wr(1'h0, 8'h80);
    host_u.xfer(1'h1, 1'h0, v);
    check("ack1_oe", {v[8], 8'h00}, 9'h000);
    check("int_nested", {8'h00, irq}, 9'h001);
    req = 8'h00;
    host_u.xfer(1'h1, 1'h0, v);
    check("ack2_two", v, 9'h14b);
    check("ben_buf", {8'h00, ben_seen}, 9'h000);
    host_u.wr(1'h0, 8'h0b);
    rdc(1'h0, 8'h00, "isr_auto");
    setreq(8'h11);
    pollc(8'h84);
    host_u.wr(1'h0, 8'h64);
    host_u.wr(1'h0, 8'h00);
    setreq(8'h01);
    host_u.xfer(1'h1, 1'h0, v);
    req = 8'h00;
    host_u.xfer(1'h1, 1'h0, v);
    check("ack2_lvl0", v, 9'h148);
    setreq(8'h12);
    pollc(8'h84);
    host_u.wr(1'h0, 8'h64);
    req = 8'h00;
    $display("test level_auto done");
    end_sim();
  end
endmodule : pic_core_tb_top
